// *** include/mmdec_pkg.sv ***
package mmdec_pkg;
	// --------------------------------------------------------------
	// Modes and memory configurations
	// --------------------------------------------------------------
	// Order follows the two-bit mode field, 00b to 11b
	typedef enum logic [1:0] {mode_zero, mode_one, mode_two, mode_three} mode_t;
	// Fitted RAM: one or two 128K parts, one or two 512K parts
	typedef enum logic [1:0] {ram_128k, ram_256k, ram_512k, ram_1m} ram_cfg_t;

	// --------------------------------------------------------------
	// Control port
	// --------------------------------------------------------------
	localparam logic [15:0] ctrl_port_addr = 16'hfa05;
	localparam int mode_lsb = 5;
	localparam int mode_msb = 6;
	localparam logic [7:0] ctrl_reset = 8'h00;

	// --------------------------------------------------------------
	// Memory map
	// --------------------------------------------------------------
	localparam logic [19:0] win_lo = 20'ha0000;
	localparam logic [19:0] win_mid = 20'hc0000;
	localparam logic [19:0] rom_top = 20'he0000;
	localparam logic [19:0] win_shift = 20'h80000;
	localparam logic [19:0] ram_128k_end = 20'h20000;
	localparam logic [19:0] ram_256k_end = 20'h40000;
	localparam logic [19:0] ram_512k_end = 20'h80000;
	localparam logic [1:0] part_top_128k = 2'h3;
	localparam logic [1:0] part_low_128k = 2'h0;

	// --------------------------------------------------------------
	// I/O map
	// --------------------------------------------------------------
	localparam logic [15:0] io_exp_base = 16'hfc00;
	localparam logic [15:0] io_cpu_base = 16'hfff0;
	localparam logic [6:0] io_board_page = 7'h7d;
	localparam int io_sel_count = 4;

	// --------------------------------------------------------------
	// Carriers
	// --------------------------------------------------------------
	// One processor cycle offered to the decoder
	typedef struct packed {
		logic valid;
		logic io;
		logic wr;
		logic [19:0] addr;
		logic [7:0] wdata;
	} bus_req_t;

	// Straps, high while fitted
	typedef struct packed {
		logic software_select_strap_a;
		logic software_select_strap_b;
		logic mode_strap_low;
		logic mode_strap_high;
	} strap_t;

	// On-board I/O selects; sel[0..3] is parallel, clock, module 0, module 1
	typedef struct packed {
		logic cpu_cfg;
		logic ctrl;
		logic [3:0] sel;
	} io_sel_t;

	// Registered result of one decoded cycle
	typedef struct packed {
		logic valid;
		logic rom_cs;
		logic ram0_cs;
		logic ram1_cs;
		logic [18:0] part_addr;
		logic backplane;
		logic ioexp_n;
		io_sel_t io_sel;
		logic [7:0] rdata;
	} dec_out_t;

	localparam dec_out_t out_idle = '{ioexp_n: 1'b1, default: '0};
endpackage : mmdec_pkg

// *** tb/board_far_side.sv ***
`timescale 1ns/1ns
module board_far_side (
	// Decoder result
	input mmdec_pkg::dec_out_t dec,
	// Number of parties answering the cycle
	output logic [2:0] claims
);
	// ------------------------------------------------------------
	// Answer counting
	// ------------------------------------------------------------
	// Sockets, on-board I/O and backplane each answer; two at once would fight on the bus
	always_comb begin
		claims = 3'h0;
		if (dec.valid) begin
			claims = 3'(dec.rom_cs) + 3'(dec.ram0_cs) + 3'(dec.ram1_cs) + 3'(dec.backplane)
				+ 3'(|dec.io_sel);
		end
	end
endmodule : board_far_side

// *** tb/memory_mode_io_decoder_tb_top.sv ***
`timescale 1ns/1ns
module memory_mode_io_decoder_tb_top;
	// ------------------------------------------------------------
	// Stimulus and observation
	// ------------------------------------------------------------
	logic clk = 1'b0; // 50 MHz
	logic rstn = 1'b0; // Active-low reset
	mmdec_pkg::bus_req_t req = '0; // Offered cycle
	mmdec_pkg::strap_t straps = 4'h8; // First select strap fitted: software control
	mmdec_pkg::ram_cfg_t ram_cfg = mmdec_pkg::ram_1m;
	logic rom_512k = 1'b1;
	mmdec_pkg::dec_out_t dec; // Decoded result
	mmdec_pkg::dec_out_t got; // Result taken one cycle after the request
	logic [2:0] claims; // Answering parties
	int n_mismatch = 0;
	int checks = 0;
	int seed = 47;
	logic [7:0] port = 8'h00; // Expected control port byte
	logic [1:0] mode = 2'h0; // Expected mode
	logic [19:0] a;
	logic [15:0] corner[10] = '{16'hfa00, 16'hfa05, 16'hfa7f, 16'hfa80, 16'hfbff, 16'hfc00,
		16'hffef, 16'hfff0, 16'hf9ff, 16'hffff};

	memory_mode_io_decoder i_memory_mode_io_decoder (.clk(clk), .rstn(rstn), .req(req),
		.straps(straps), .ram_cfg(ram_cfg), .rom_512k(rom_512k), .dec(dec));
	board_far_side i_board_far_side (.dec(dec), .claims(claims));

	// Free-running clock
	initial begin
		forever #10 clk = ~clk;
	end

	// ------------------------------------------------------------
	// Expectations
	// ------------------------------------------------------------
	// Memory selects {rom, ram0, ram1, backplane, part address}
	function automatic logic [22:0] exp_mem(input logic [19:0] ad);
		logic [2:0] cs;
		logic [18:0] p;
		logic [19:0] d;
		cs = 3'h0;
		p = ad[18:0];
		d = ad - 20'h80000;
		if (ad >= 20'he0000) begin
			cs = 3'h4;
			p = {2'h3, ad[16:0]};
		end else if (ad < 20'ha0000) begin
			case (ram_cfg)
				mmdec_pkg::ram_128k: cs = {1'b0, ad < 20'h20000, 1'b0};
				mmdec_pkg::ram_256k: cs = {1'b0, ad < 20'h20000, ad >= 20'h20000 && ad < 20'h40000};
				mmdec_pkg::ram_512k: cs = {1'b0, ad < 20'h80000, 1'b0};
				default: cs = {1'b0, ad < 20'h80000, ad >= 20'h80000};
			endcase
		end else if (mode == 2'h1 && rom_512k) begin
			cs = 3'h4;
			p = d[18:0];
		end else if (mode == 2'h2 && ad >= 20'hc0000) begin
			cs = {rom_512k, 2'h0};
			p = {2'h0, ad[16:0]};
		end else if (mode[1] && ram_cfg == mmdec_pkg::ram_1m) begin
			cs = 3'h1;
			p = mode[0] ? d[18:0] : {2'h3, ad[16:0]};
		end
		// Part address only matters while a part is selected
		return {cs, ~|cs, (|cs) ? p : 19'h0};
	endfunction : exp_mem

	// I/O result {backplane, expansion line, cpu, ctrl, sel}
	function automatic logic [7:0] exp_io(input logic [15:0] ad);
		logic [3:0] s;
		logic c;
		for (int k = 0; k < 4; k++) s[k] = (ad[15:7] == 9'h1f4 + 9'(k));
		c = ad >= 16'hfff0;
		return {~(|s | c), ad < 16'hfc00, c, ad == 16'hfa05, s};
	endfunction : exp_io

	// ------------------------------------------------------------
	// Tasks
	// ------------------------------------------------------------
	task automatic check(input logic [47:0] g, input logic [47:0] e);
		checks++;
		if (g !== e) begin
			n_mismatch++;
			$display("unexpected at %0t: got %h, expected %h", $time, g, e);
		end
	endtask : check

	// Offer one cycle; valid is left high afterwards, so back-to-back calls never drop it between cycles
	task automatic access(input logic io, input logic wr, input logic [19:0] ad,
		input logic [7:0] wd);
		req <= '{valid: 1'b1, io: io, wr: wr, addr: ad, wdata: wd};
		@(posedge clk);
		#1;
		got = dec;
		check(48'(got.valid), 48'h1);
		check(48'(claims), 48'h1);
	endtask : access

	// Random memory cycle, biased into the banked window
	task automatic mem_rand();
		a = 20'($random(seed));
		a = a[0] ? 20'ha0000 + {2'h0, a[19:2]} : a;
		ram_cfg = mmdec_pkg::ram_cfg_t'(2'($random(seed)));
		rom_512k = 1'($random(seed));
		access(1'b0, 1'($random(seed)), a, 8'h00);
		check(48'({got.rom_cs, got.ram0_cs, got.ram1_cs, got.backplane,
			got.backplane ? 19'h0 : got.part_addr}), 48'(exp_mem(a)));
	endtask : mem_rand

	// Read-modify-write of the control port
	task automatic set_mode(input logic [1:0] m);
		access(1'b1, 1'b0, 20'h0fa05, 8'h00);
		check(48'(got.rdata), 48'(port));
		port = {port[7], m, port[4:0]};
		access(1'b1, 1'b1, 20'h0fa05, port);
		mode = m;
	endtask : set_mode

	task automatic wrap_up();
		if (n_mismatch == 0 && checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : wrap_up

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		repeat (20) @(posedge clk);
		check(48'(dec), 48'(mmdec_pkg::out_idle));
		#1;
		rstn = 1'b1;
		repeat (30) mem_rand();
		// Random byte into the port, mode field left at zero, read back next cycle
		port = 8'($random(seed));
		port[6:5] = 2'h0;
		access(1'b1, 1'b1, 20'h0fa05, port);
		for (int m = 0; m < 4; m++) begin
			set_mode(m[1:0]);
			repeat (40) mem_rand();
		end
		// Hardwired modes, starting from one the port does not hold
		for (int m = 0; m < 4; m++) begin
			straps = {2'h0, m[0], m[1]};
			mode = m[1:0];
			repeat (2) @(posedge clk);
			#1;
			repeat (25) mem_rand();
		end
		// Second select strap alone hands control back to the port
		straps = 4'h4;
		set_mode(2'h2);
		repeat (20) mem_rand();
		// I/O corners, then random addresses biased onto the board page
		foreach (corner[i]) io_one({4'h0, corner[i]});
		for (int i = 0; i < 80; i++) begin
			a = 20'($random(seed));
			a[15:9] = a[0] ? 7'h7d : a[15:9];
			io_one(a);
		end
		wrap_up();
	end

	task automatic io_one(input logic [19:0] ad);
		access(1'b1, 1'b0, ad, 8'h00);
		check(48'({got.backplane, got.ioexp_n, got.io_sel}), 48'(exp_io(ad[15:0])));
	endtask : io_one

	// Watchdog, far beyond the roughly 440 cycles the run needs
	initial begin
		#100000;
		n_mismatch++;
		wrap_up();
	end
endmodule : memory_mode_io_decoder_tb_top

// *** verilog/io_select_decode.sv ***
`timescale 1ns/1ns
module io_select_decode (
	// Full I/O address
	input wire logic [15:0] io_addr,
	// On-board selects
	output mmdec_pkg::io_sel_t sel
);
	// ------------------------------------------------------------
	// Board page selects
	// ------------------------------------------------------------
	// All seven upper bits 15:9 take part, so no alias appears below the page
	logic page_hit;
	assign page_hit = (io_addr[15:9] == mmdec_pkg::io_board_page);

	// Four 128-byte slots, picked by address bits 8:7
	genvar gi;
	generate
		for (gi = 0; gi < mmdec_pkg::io_sel_count; gi++) begin : g_slot
			assign sel.sel[gi] = page_hit && (io_addr[8:7] == 2'(gi));
		end
	endgenerate

	// Control port sits inside the parallel slot
	assign sel.ctrl = (io_addr == mmdec_pkg::ctrl_port_addr);
	// Processor configuration block stays on the board
	assign sel.cpu_cfg = (io_addr >= mmdec_pkg::io_cpu_base);
endmodule : io_select_decode

// *** verilog/memory_mode_io_decoder.sv ***
// Behaviour
// - Top 128K ROM always high; low memory untouched
// - Mode zero sends whole window to backplane
// - Mode zero from reset until changed
// - Mode one maps ROM middle 256K to window
// - Mode two maps ROM bottom 128K at C0000h
// - Mode two maps RAM1 top 128K at A0000h
// - Mode three maps RAM1 middle 256K to window
// - Software mode from control port bits 6:5
// - Mode codes 00b..11b give modes zero..three
// - Straps removed: mode from two mode straps
// - Decode all sixteen I/O address bits
// - Expansion line low for I/O FC00h-FFFFh
// - Selects for parallel, clock, two modules
`timescale 1ns/1ns
module memory_mode_io_decoder (
	// Clock and reset
	input wire logic clk,
	input wire logic rstn,
	// Processor local bus
	input mmdec_pkg::bus_req_t req,
	// Board configuration
	input mmdec_pkg::strap_t straps,
	input mmdec_pkg::ram_cfg_t ram_cfg,
	input wire logic rom_512k,
	// Decoded selects
	output mmdec_pkg::dec_out_t dec
);
	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	typedef struct packed {
		logic [7:0] ctrl;
		mmdec_pkg::mode_t mode;
		mmdec_pkg::dec_out_t out;
	} state_t;

	state_t st_ff; // Registered state
	state_t nxt_st; // Next state
	mmdec_pkg::io_sel_t io_sel; // I/O selects of this cycle
	logic [19:0] win_off; // Window address moved down by 512K
	logic sw_ctl; // Software owns the mode

	// ------------------------------------------------------------
	// I/O select decode
	// ------------------------------------------------------------
	io_select_decode u_io_sel (
		.io_addr(req.addr[15:0]),
		.sel(io_sel)
	);

	assign win_off = req.addr - mmdec_pkg::win_shift;
	assign sw_ctl = straps.software_select_strap_a || straps.software_select_strap_b;
	assign dec = st_ff.out;

	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------
	// Mode follows the port value written in the same edge, so the
	// very next cycle already decodes with it.
	always_comb begin
		logic [7:0] ctrl_n;
		ctrl_n = st_ff.ctrl;
		nxt_st = st_ff;
		nxt_st.out = mmdec_pkg::out_idle;
		nxt_st.out.valid = req.valid;
		// Whole byte is stored; software keeps the other bits itself
		if (req.valid && req.io && req.wr && io_sel.ctrl) begin
			ctrl_n = req.wdata;
		end
		nxt_st.ctrl = ctrl_n;
		// Mode source: port when a select strap is fitted, else straps
		if (sw_ctl) begin
			nxt_st.mode = mmdec_pkg::mode_t'(ctrl_n[mmdec_pkg::mode_msb:mmdec_pkg::mode_lsb]);
		end else begin
			nxt_st.mode = mmdec_pkg::mode_t'({straps.mode_strap_high, straps.mode_strap_low});
		end
		if (req.valid && req.io) begin
			// I/O cycle
			nxt_st.out.io_sel = io_sel;
			nxt_st.out.ioexp_n = !(req.addr[15:0] >= mmdec_pkg::io_exp_base);
			nxt_st.out.backplane = !(|io_sel.sel || io_sel.cpu_cfg);
			if (io_sel.ctrl && !req.wr) begin
				nxt_st.out.rdata = st_ff.ctrl;
			end
		end else if (req.valid) begin
			// Memory cycle
			if (req.addr >= mmdec_pkg::rom_top) begin
				// Top of ROM always reachable
				nxt_st.out.rom_cs = 1'b1;
				nxt_st.out.part_addr = {mmdec_pkg::part_top_128k, req.addr[16:0]};
			end else if (req.addr < mmdec_pkg::win_lo) begin
				// System RAM below the window, by configuration
				case (ram_cfg)
					mmdec_pkg::ram_128k: begin
						nxt_st.out.ram0_cs = (req.addr < mmdec_pkg::ram_128k_end);
					end
					mmdec_pkg::ram_256k: begin
						nxt_st.out.ram0_cs = (req.addr < mmdec_pkg::ram_128k_end);
						nxt_st.out.ram1_cs = (req.addr >= mmdec_pkg::ram_128k_end) &&
							(req.addr < mmdec_pkg::ram_256k_end);
					end
					mmdec_pkg::ram_512k: begin
						nxt_st.out.ram0_cs = (req.addr < mmdec_pkg::ram_512k_end);
					end
					default: begin
						nxt_st.out.ram0_cs = (req.addr < mmdec_pkg::ram_512k_end);
						nxt_st.out.ram1_cs = (req.addr >= mmdec_pkg::ram_512k_end);
					end
				endcase
				nxt_st.out.part_addr = req.addr[18:0];
			end else begin
				// Bank-switched window A0000h-DFFFFh
				case (st_ff.mode)
					mmdec_pkg::mode_one: begin
						nxt_st.out.rom_cs = rom_512k;
						nxt_st.out.part_addr = win_off[18:0];
					end
					mmdec_pkg::mode_two: begin
						if (req.addr >= mmdec_pkg::win_mid) begin
							nxt_st.out.rom_cs = rom_512k;
							nxt_st.out.part_addr = {mmdec_pkg::part_low_128k, req.addr[16:0]};
						end else begin
							nxt_st.out.ram1_cs = (ram_cfg == mmdec_pkg::ram_1m);
							nxt_st.out.part_addr = {mmdec_pkg::part_top_128k, req.addr[16:0]};
						end
					end
					mmdec_pkg::mode_three: begin
						nxt_st.out.ram1_cs = (ram_cfg == mmdec_pkg::ram_1m);
						nxt_st.out.part_addr = win_off[18:0];
					end
					default: begin
						// Mode zero: nothing on board claims the window
						nxt_st.out.part_addr = '0;
					end
				endcase
			end
			// Anything not claimed on board goes to the backplane
			nxt_st.out.backplane = !(nxt_st.out.rom_cs || nxt_st.out.ram0_cs ||
				nxt_st.out.ram1_cs);
		end
	end

	// ------------------------------------------------------------
	// State register
	// ------------------------------------------------------------
	// Mode zero out of reset; straps are read only after release
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			st_ff <= '{ctrl: mmdec_pkg::ctrl_reset, mode: mmdec_pkg::mode_zero,
				out: mmdec_pkg::out_idle};
		end else begin
			st_ff <= nxt_st;
		end
	end

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);

	sequence s_mem(logic [19:0] lo, logic [19:0] hi);
		req.valid && !req.io && req.addr >= lo && req.addr <= hi;
	endsequence

	sequence s_io(logic [15:0] lo, logic [15:0] hi);
		req.valid && req.io && req.addr[15:0] >= lo && req.addr[15:0] <= hi;
	endsequence

	property p_top_rom;
		s_mem(20'he0000, 20'hfffff) |=> dec.valid && dec.rom_cs && !dec.backplane &&
			dec.part_addr == {2'h3, $past(req.addr[16:0])};
	endproperty
	a_top_rom: assert property (p_top_rom) else $error("top ROM not selected");

	property p_low_no_rom;
		s_mem(20'h00000, 20'h9ffff) |=> !dec.rom_cs;
	endproperty
	a_low_no_rom: assert property (p_low_no_rom) else $error("ROM below window");

	property p_mode0_off;
		st_ff.mode == mmdec_pkg::mode_zero ##0 s_mem(20'ha0000, 20'hdffff) |=>
			dec.backplane && !dec.rom_cs && !dec.ram0_cs && !dec.ram1_cs;
	endproperty
	a_mode0_off: assert property (p_mode0_off) else $error("mode zero claimed window");

	property p_mode_hold;
		!(req.valid && req.io && req.wr) && $stable(straps) && sw_ctl |=> $stable(st_ff.mode);
	endproperty
	a_mode_hold: assert property (p_mode_hold) else $error("mode moved on its own");

	property p_mode1;
		st_ff.mode == mmdec_pkg::mode_one && rom_512k ##0 s_mem(20'ha0000, 20'hdffff) |=>
			dec.rom_cs && dec.part_addr == 19'($past(req.addr) - 20'h80000);
	endproperty
	a_mode1: assert property (p_mode1) else $error("mode one mapping wrong");

	property p_mode2;
		st_ff.mode == mmdec_pkg::mode_two && rom_512k && ram_cfg == mmdec_pkg::ram_1m
			##0 s_mem(20'ha0000, 20'hdffff) |=> dec.part_addr[16:0] == $past(req.addr[16:0]) &&
			(dec.rom_cs ? dec.part_addr[18:17] == 2'h0 : dec.ram1_cs && dec.part_addr[18:17] == 2'h3);
	endproperty
	a_mode2: assert property (p_mode2) else $error("mode two mapping wrong");

	property p_mode3;
		st_ff.mode == mmdec_pkg::mode_three && ram_cfg == mmdec_pkg::ram_1m
			##0 s_mem(20'ha0000, 20'hdffff) |=> dec.ram1_cs && !dec.rom_cs &&
			dec.part_addr == 19'($past(req.addr) - 20'h80000);
	endproperty
	a_mode3: assert property (p_mode3) else $error("mode three mapping wrong");

	property p_sw_mode;
		sw_ctl && req.valid && req.io && req.wr && req.addr[15:0] == 16'hfa05 |=>
			st_ff.mode == mmdec_pkg::mode_t'($past(req.wdata[6:5]));
	endproperty
	a_sw_mode: assert property (p_sw_mode) else $error("port write did not set mode");

	property p_strap_mode;
		!sw_ctl |=> st_ff.mode == mmdec_pkg::mode_t'($past({straps.mode_strap_high,
			straps.mode_strap_low}));
	endproperty
	a_strap_mode: assert property (p_strap_mode) else $error("strap mode not taken");

	property p_ioexp;
		req.valid |=> dec.valid && (dec.ioexp_n == !($past(req.io) &&
			$past(req.addr[15:0]) >= 16'hfc00));
	endproperty
	a_ioexp: assert property (p_ioexp) else $error("expansion line wrong");

	property p_rtc_sel;
		s_io(16'hfa80, 16'hfaff) |=> dec.io_sel.sel == 4'h2 && !dec.backplane;
	endproperty
	a_rtc_sel: assert property (p_rtc_sel) else $error("clock select wrong");

	property p_io_off;
		s_io(16'h0000, 16'hf9ff) |=> dec.backplane && dec.io_sel.sel == 4'h0;
	endproperty
	a_io_off: assert property (p_io_off) else $error("low I/O not forwarded");

	// ------------------------------------------------------------
	// Checks on the board page, the port and the RAM map
	// ------------------------------------------------------------
	// Control port cycles, write then read back
	sequence s_port_wr;
		req.valid && req.io && req.wr && req.addr[15:0] == 16'hfa05;
	endsequence

	sequence s_port_rd;
		req.valid && req.io && !req.wr && req.addr[15:0] == 16'hfa05;
	endsequence

	// Out of reset the window is off board and nothing is selected
	property p_reset_mode;
		$rose(rstn) |-> st_ff.mode == mmdec_pkg::mode_zero && dec == mmdec_pkg::out_idle;
	endproperty
	a_reset_mode: assert property (p_reset_mode) else $error("not idle in mode zero");

	// Whole byte comes back, so software can keep the bits it does not own
	property p_port_back;
		s_port_wr ##1 s_port_rd |=> dec.rdata == $past(req.wdata, 2);
	endproperty
	a_port_back: assert property (p_port_back) else $error("port byte not read back");

	// Parallel slot, control port included; expansion line stays high
	property p_par_sel;
		s_io(16'hfa00, 16'hfa7f) |=> dec.io_sel.sel == 4'h1 && !dec.backplane && dec.ioexp_n;
	endproperty
	a_par_sel: assert property (p_par_sel) else $error("parallel select wrong");

	property p_mod0_sel;
		s_io(16'hfb00, 16'hfb7f) |=> dec.io_sel.sel == 4'h4 && !dec.backplane;
	endproperty
	a_mod0_sel: assert property (p_mod0_sel) else $error("module 0 select wrong");

	property p_mod1_sel;
		s_io(16'hfb80, 16'hfbff) |=> dec.io_sel.sel == 4'h8 && !dec.backplane;
	endproperty
	a_mod1_sel: assert property (p_mod1_sel) else $error("module 1 select wrong");

	// Eight-bit boards live here, so the line must go low and the cycle leave the board
	property p_exp_off;
		s_io(16'hfc00, 16'hffef) |=> dec.backplane && !dec.ioexp_n && dec.io_sel == '0;
	endproperty
	a_exp_off: assert property (p_exp_off) else $error("expansion range wrong");

	// Processor configuration stays on board, yet the line still goes low
	property p_cpu_cfg;
		s_io(16'hfff0, 16'hffff) |=> dec.io_sel.cpu_cfg && !dec.backplane && !dec.ioexp_n;
	endproperty
	a_cpu_cfg: assert property (p_cpu_cfg) else $error("configuration range wrong");

	// Second 512K part sits right under the window
	property p_low_ram1;
		ram_cfg == mmdec_pkg::ram_1m ##0 s_mem(20'h80000, 20'h9ffff) |=>
			dec.ram1_cs && !dec.ram0_cs && dec.part_addr == 19'($past(req.addr));
	endproperty
	a_low_ram1: assert property (p_low_ram1) else $error("second RAM not selected");

	// A small RAM leaves a gap that the backplane must fill
	property p_ram_gap;
		ram_cfg == mmdec_pkg::ram_128k ##0 s_mem(20'h20000, 20'h9ffff) |=>
			dec.backplane && !dec.ram0_cs && !dec.ram1_cs;
	endproperty
	a_ram_gap: assert property (p_ram_gap) else $error("RAM gap not forwarded");

	// Mode three without the second large RAM claims nothing
	property p_mode3_off;
		st_ff.mode == mmdec_pkg::mode_three && ram_cfg != mmdec_pkg::ram_1m
			##0 s_mem(20'ha0000, 20'hdffff) |=> dec.backplane && !dec.ram1_cs;
	endproperty
	a_mode3_off: assert property (p_mode3_off) else $error("unfitted RAM claimed");
endmodule : memory_mode_io_decoder
